// file: icc_pkg.sv
// Package of constants and types for the input capture channel
package icc_pkg;
    // Register byte offsets
    localparam logic [7:0] ICC_OFF_CTRL   = 8'h00;
    localparam logic [7:0] ICC_OFF_BUF    = 8'h04;
    localparam logic [7:0] ICC_OFF_IRQST  = 8'h08;
    localparam logic [7:0] ICC_OFF_IRQMSK = 8'h0C;
    // Control field positions
    localparam int ICC_MODE_LSB   = 0;
    localparam int ICC_BNE_BIT    = 3;
    localparam int ICC_OV_BIT     = 4;
    localparam int ICC_IVL_LSB    = 5;
    localparam int ICC_TSEL_BIT   = 7;
    localparam int ICC_SIDL_BIT   = 13;
    // Interrupt status bit positions
    localparam int ICC_IRQ_CAP    = 0;
    localparam int ICC_IRQ_WAKE   = 1;
    localparam int ICC_IRQ_OVF    = 2;
    localparam int ICC_IRQ_W      = 3;
    // Reset values
    localparam logic [15:0] ICC_CTRL_RST = 16'h0000;
    localparam logic [ICC_IRQ_W-1:0] ICC_MSK_RST = 3'h0;
    // Buffer depth and prescale counts
    localparam int ICC_DEPTH      = 4;
    localparam logic [3:0] ICC_PRE4_LAST  = 4'h3;
    localparam logic [3:0] ICC_PRE16_LAST = 4'hF;
    // Capture modes
    typedef enum logic [2:0] {
        ICC_M_OFF   = 3'h0,
        ICC_M_BOTH  = 3'h1,
        ICC_M_RISE  = 3'h2,
        ICC_M_FALL  = 3'h3,
        ICC_M_PRE4  = 3'h4,
        ICC_M_PRE16 = 3'h5,
        ICC_M_UNUSED = 3'h6,
        ICC_M_WAKE  = 3'h7
    } icc_mode_t;
    // Bus slave phase
    typedef enum logic [1:0] {
        ICC_S_IDLE = 2'b01,
        ICC_S_DATA = 2'b10
    } icc_bus_t;
endpackage

// file: icc_fifo.sv
// Four-word capture buffer, oldest first
`timescale 1ns/1ps
module icc_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    // Write side
    input  wire logic             push_i,
    input  wire logic [WIDTH-1:0] data_i,
    // Read side
    input  wire logic             pop_i,
    output logic      [WIDTH-1:0] data_o,
    output logic                  empty_o,
    output logic                  full_o,
    output logic [$clog2(DEPTH):0] count_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    wire              do_push = push_i && !full_o;
    wire              do_pop  = pop_i && !empty_o;

    assign empty_o = (count == '0);
    assign full_o  = (count == (AW+1)'(DEPTH));
    assign data_o  = mem[rd_ptr];
    assign count_o = count;

    always_ff @(posedge clk_i) begin
        if (do_push) begin
            mem[wr_ptr] <= data_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (do_push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (do_pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            count <= count + (AW+1)'(do_push) - (AW+1)'(do_pop);
        end
    end
endmodule

// file: icc_top.sv
// Input capture channel with AHB-Lite register slave
`timescale 1ns/1ps
module icc_top
    import icc_pkg::*;
#(
    parameter int DEPTH = ICC_DEPTH
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    // AHB-Lite slave
    input  wire logic        hsel_i,
    input  wire logic [7:0]  haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic      [31:0] hrdata_o,
    output logic             hreadyout_o,
    output logic             hresp_o,
    // Capture pin and time bases
    input  wire logic        capture_input_pin_i,
    input  wire logic [15:0] second_timer_count_i,
    input  wire logic [15:0] third_timer_count_i,
    // Power state of the core
    input  wire logic        cpu_idle_i,
    input  wire logic        cpu_sleep_i,
    // Interrupt and wake
    output logic             irq_o,
    output logic             wake_o
);
    import icc_pkg::*;

    // Registers, counters and control register fields
    logic [15:0] ctrl;
    logic [ICC_IRQ_W-1:0] irq_stat;
    logic [ICC_IRQ_W-1:0] irq_mask;
    logic        ovf;
    logic        pin_q;
    logic [3:0]  pre_cnt;
    logic [1:0]  ivl_cnt;

    wire icc_mode_t mode = icc_mode_t'(ctrl[ICC_MODE_LSB +: 3]);
    wire [1:0]   ivl_fld  = ctrl[ICC_IVL_LSB +: 2];
    wire         tsel     = ctrl[ICC_TSEL_BIT];
    wire         sidl     = ctrl[ICC_SIDL_BIT];

    // Bus address phase capture
    logic        dp_wr;
    logic        dp_rd;
    logic [7:0]  dp_addr;
    icc_bus_t    bus_st;

    wire addr_ok = hsel_i && hready_i && htrans_i[1];
    wire wr_ctrl = dp_wr && (dp_addr == ICC_OFF_CTRL);
    wire wr_st   = dp_wr && (dp_addr == ICC_OFF_IRQST);
    wire wr_msk  = dp_wr && (dp_addr == ICC_OFF_IRQMSK);
    wire rd_buf  = addr_ok && !hwrite_i && (haddr_i == ICC_OFF_BUF);

    // Edge detection on the synchronous pin
    wire rise = capture_input_pin_i && !pin_q;
    wire fall = !capture_input_pin_i && pin_q;

    wire halted = sidl && cpu_idle_i;

    wire ev_fall  = (mode == ICC_M_FALL) && fall;
    wire ev_rise  = (mode == ICC_M_RISE) && rise;
    wire ev_both  = (mode == ICC_M_BOTH) && (rise || fall);
    wire ev_pre4  = (mode == ICC_M_PRE4) && rise
                    && (pre_cnt == ICC_PRE4_LAST);
    wire ev_pre16 = (mode == ICC_M_PRE16) && rise
                    && (pre_cnt == ICC_PRE16_LAST);
    wire cap_ev   = !halted
                    && (ev_fall || ev_rise || ev_both || ev_pre4 || ev_pre16);

    // wake-only mode, rising edge, asleep or idle
    wire wake_ev  = (mode == ICC_M_WAKE) && rise
                    && (cpu_sleep_i || cpu_idle_i);

    wire [15:0] cap_val = tsel ? second_timer_count_i : third_timer_count_i;

    logic [15:0] fifo_q;
    logic        fifo_empty;
    logic        fifo_full;

    icc_fifo #(
        .WIDTH (16),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .push_i  (cap_ev),
        .data_i  (cap_val),
        .pop_i   (rd_buf),
        .data_o  (fifo_q),
        .empty_o (fifo_empty),
        .full_o  (fifo_full),
        .count_o ()
    );

    wire ivl_hit = cap_ev && ((mode == ICC_M_BOTH) || (ivl_cnt == ivl_fld));

    wire ovf_set = cap_ev && fifo_full;

    wire [ICC_IRQ_W-1:0] ev_vec = {ovf_set, wake_ev, ivl_hit};
    wire [ICC_IRQ_W-1:0] next_irq_stat = (irq_stat
                         & ~(wr_st ? hwdata_i[ICC_IRQ_W-1:0] : '0)) | ev_vec;

    wire [15:0] ctrl_rd = {ctrl[15:8], ctrl[7:5], ovf, !fifo_empty,
                           ctrl[2:0]};

    wire [31:0] next_rdata =
        (haddr_i == ICC_OFF_CTRL)   ? {16'h0000, ctrl_rd} :
        (haddr_i == ICC_OFF_BUF)    ? {16'h0000, fifo_q} :
        (haddr_i == ICC_OFF_IRQST)  ? {29'h0000000, irq_stat} :
        (haddr_i == ICC_OFF_IRQMSK) ? {29'h0000000, irq_mask} :
                                      32'h00000000;

    // Writable control bits only; flags stay hardware owned
    wire [15:0] ctrl_wmask = 16'h20E7;

    // Bus phase tracking; slave answers with zero wait states
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bus_st  <= ICC_S_IDLE;
            dp_wr   <= 1'b0;
            dp_rd   <= 1'b0;
            dp_addr <= 8'h00;
        end else begin
            dp_wr   <= addr_ok && hwrite_i;
            dp_rd   <= addr_ok && !hwrite_i;
            dp_addr <= haddr_i;
            case (bus_st)
                ICC_S_IDLE: bus_st <= addr_ok ? ICC_S_DATA : ICC_S_IDLE;
                ICC_S_DATA: bus_st <= addr_ok ? ICC_S_DATA : ICC_S_IDLE;
                default:    bus_st <= ICC_S_IDLE;
            endcase
        end
    end

    // Read data registered in the address phase
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hrdata_o    <= 32'h00000000;
            hreadyout_o <= 1'b1;
            hresp_o     <= 1'b0;
        end else begin
            hrdata_o    <= (addr_ok && !hwrite_i) ? next_rdata : 32'h00000000;
            hreadyout_o <= 1'b1;
            hresp_o     <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl     <= ICC_CTRL_RST;
            irq_mask <= ICC_MSK_RST;
        end else begin
            if (wr_ctrl) begin
                ctrl <= hwdata_i[15:0] & ctrl_wmask;
            end
            if (wr_msk) begin
                irq_mask <= hwdata_i[ICC_IRQ_W-1:0];
            end
        end
    end

    // Prescale and interval counters restart on any control write
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_q   <= 1'b0;
            pre_cnt <= 4'h0;
            ivl_cnt <= 2'h0;
        end else begin
            pin_q <= capture_input_pin_i;
            if (wr_ctrl) begin
                pre_cnt <= 4'h0;
                ivl_cnt <= 2'h0;
            end else begin
                if (!halted && rise && (mode == ICC_M_PRE4
                                        || mode == ICC_M_PRE16)) begin
                    pre_cnt <= (ev_pre4 || ev_pre16) ? 4'h0 : pre_cnt + 4'h1;
                end
                if (cap_ev) begin
                    ivl_cnt <= ivl_hit ? 2'h0 : ivl_cnt + 2'h1;
                end
            end
        end
    end

    // overflow clears on buffer read; set wins
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ovf <= 1'b0;
        end else if (ovf_set) begin
            ovf <= 1'b1;
        end else if (rd_buf) begin
            ovf <= 1'b0;
        end
    end

    // Sticky status, write one to clear, set wins
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_stat <= '0;
            irq_o    <= 1'b0;
            wake_o   <= 1'b0;
        end else begin
            irq_stat <= next_irq_stat;
            irq_o    <= |(next_irq_stat & irq_mask);
            wake_o   <= wake_ev;
        end
    end
endmodule

// file: icc_asserts.sv
// Port-level checker for the input capture channel
`timescale 1ns/1ps
module icc_asserts
    import icc_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        rst_n_i,
    input wire logic        hsel_i,
    input wire logic [7:0]  haddr_i,
    input wire logic [1:0]  htrans_i,
    input wire logic        hwrite_i,
    input wire logic        hready_i,
    input wire logic [31:0] hrdata_o,
    input wire logic        hreadyout_o,
    input wire logic        hresp_o,
    input wire logic        cpu_idle_i,
    input wire logic        cpu_sleep_i,
    input wire logic        irq_o,
    input wire logic        wake_o
);
    wire go = hsel_i & hready_i & htrans_i[1];
    wire rd = go & ~hwrite_i;
    wire wr = go & hwrite_i;
    wire lp = cpu_sleep_i | cpu_idle_i;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    a_resp_okay: assert property (hresp_o == 1'b0)
        else $error("error response seen");
    a_ready_always: assert property (hreadyout_o == 1'b1)
        else $error("wait state inserted");
    a_rdata_idle: assert property (!rd |=> hrdata_o == 32'h0)
        else $error("read data left standing");
    a_unmapped_zero: assert property (rd && haddr_i > 8'h0C
        |=> hrdata_o == 32'h0)
        else $error("unmapped read not zero");
    a_ctrl_reserved: assert property (rd && haddr_i == ICC_OFF_CTRL
        |=> {hrdata_o[31:14], hrdata_o[12:8]} == 23'h0)
        else $error("reserved control bits not zero");
    a_buf_width: assert property (
        rd && haddr_i == ICC_OFF_BUF |=> hrdata_o[31:16] == 16'h0)
        else $error("buffer read wider than 16 bits");
    a_wake_pulse: assert property (wake_o |=> !wake_o)
        else $error("wake longer than one cycle");
    a_wake_lowpower: assert property (wake_o |-> $past(lp))
        else $error("wake while core running");
    a_irq_fall: assert property ($fell(irq_o)
        |-> $past(wr) || $past(wr, 2) || $past(wr, 3))
        else $error("interrupt dropped without a write");
endmodule

bind icc_top icc_asserts u_asserts (
    .clk_i, .rst_n_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hready_i,
    .hrdata_o, .hreadyout_o, .hresp_o, .cpu_idle_i, .cpu_sleep_i, .irq_o,
    .wake_o
);

// file: icc_pin_src.sv
// External signal source driving the capture pin
`timescale 1ns/1ps
module icc_pin_src (
    // Clock
    input  wire logic clk_i,
    // Pin level
    output logic      pin_o
);
    initial pin_o = 1'b0;
    // Each level held a few cycles so every edge is seen once
    task automatic level(input logic v);
        @(posedge clk_i);
        pin_o <= v;
        repeat (3) @(posedge clk_i);
    endtask
    task automatic pulses(input int n);
        repeat (n) begin
            level(1'b1);
            level(1'b0);
        end
    endtask
endmodule

// file: icc_top_tb_top.sv
// Self-checking bench for the input capture channel
`timescale 1ns/1ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin mismatches++; \
    $display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end
module icc_top_tb_top;
    import icc_pkg::*;
    logic        clk_i = 0;
    logic        rst_n_i = 0;
    logic        hsel = 0;
    logic        hwrite = 0;
    logic        cpu_idle = 0;
    logic        cpu_sleep = 0;
    logic [7:0]  haddr = 0;
    logic [1:0]  htrans = 0;
    logic [2:0]  hsize = 0;
    logic [31:0] hwdata = 0;
    logic [31:0] q;
    logic [15:0] t2 = 16'hA5A1;
    logic [15:0] t3 = 16'h3C3E;
    wire  [31:0] hrdata;
    wire         hreadyout, hresp, irq, wake, pin;
    int          mismatches = 0;
    int          n_compared = 0;
    int          wakes = 0;
    icc_mode_t   md[7] = '{ICC_M_BOTH, ICC_M_RISE, ICC_M_FALL, ICC_M_PRE4,
                           ICC_M_PRE16, ICC_M_OFF, ICC_M_UNUSED};
    int          np[7] = '{1, 1, 1, 7, 17, 2, 2};
    int          nc[7] = '{2, 1, 1, 1, 1, 0, 0};
    always #4 clk_i = ~clk_i;
    always @(posedge clk_i) if (wake === 1'b1) wakes++;
    icc_top u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .hsel_i(hsel),
        .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
        .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hreadyout),
        .hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(hresp),
        .capture_input_pin_i(pin), .second_timer_count_i(t2),
        .third_timer_count_i(t3), .cpu_idle_i(cpu_idle),
        .cpu_sleep_i(cpu_sleep), .irq_o(irq), .wake_o(wake));
    icc_pin_src u_pin (.clk_i(clk_i), .pin_o(pin));
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk_i);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= w;
        hsize <= 3'h2;
        do @(posedge clk_i); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clk_i); while (hreadyout !== 1'b1);
        q = hrdata;
        // Deselect between transfers so the select input moves
        hsel <= 1'b0;
    endtask
    task automatic test_done;
        $display("Compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Whole run is a few hundred cycles, far under the 25000-cycle timeout
    initial begin
        #200000;
        mismatches++;
        test_done();
    end
    initial begin
        repeat (20) @(posedge clk_i);
        rst_n_i <= 1'b1;
        bus(0, ICC_OFF_CTRL, 0);
        `CHK(q, {16'h0, ICC_CTRL_RST})
        bus(0, ICC_OFF_IRQMSK, 0);
        `CHK(q, {29'h0, ICC_MSK_RST})
        bus(0, 8'h10, 0);
        `CHK(q, 32'h0)
        bus(1, ICC_OFF_IRQMSK, 7);
        // Both-edges entry uses interval four, which must be ignored
        for (int i = 0; i < 7; i++) begin
            // Fresh second count per mode so a stale latch shows
            t2 <= 16'hA5A1 + 16'(i);
            bus(1, ICC_OFF_CTRL, {24'h0, i[0], (i == 0) ? 2'b11 : 2'b00,
                                  2'h0, md[i]});
            u_pin.pulses(np[i]);
            `CHK(irq, nc[i] > 0)
            bus(0, ICC_OFF_CTRL, 0);
            `CHK(q[3], nc[i] > 0)
            repeat (nc[i]) begin
                bus(0, ICC_OFF_BUF, 0);
                `CHK(q, {16'h0, i[0] ? t2 : t3})
            end
            bus(0, ICC_OFF_CTRL, 0);
            `CHK(q[3], 1'b0)
            bus(1, ICC_OFF_IRQST, 7);
        end
        bus(1, ICC_OFF_CTRL, 32'h62);
        for (int i = 0; i < 5; i++) begin
            t3 <= 16'h0100 + 16'(i);
            u_pin.pulses(1);
            `CHK(irq, i >= 3)
        end
        bus(0, ICC_OFF_CTRL, 0);
        `CHK(q[4:3], 2'b11)
        bus(1, ICC_OFF_IRQMSK, 0);
        repeat (3) @(posedge clk_i);
        `CHK(irq, 1'b0)
        bus(1, ICC_OFF_IRQMSK, 7);
        repeat (3) @(posedge clk_i);
        `CHK(irq, 1'b1)
        for (int i = 0; i < 4; i++) begin
            bus(0, ICC_OFF_BUF, 0);
            `CHK(q, 32'h100 + i)
        end
        bus(0, ICC_OFF_CTRL, 0);
        `CHK(q[4:3], 2'b00)
        bus(0, ICC_OFF_IRQST, 0);
        `CHK(q, 32'h5)
        bus(1, ICC_OFF_IRQST, 7);
        // Interval code 01: interrupt on every second capture
        bus(1, ICC_OFF_CTRL, 32'h22);
        for (int i = 0; i < 2; i++) begin
            u_pin.pulses(1);
            `CHK(irq, i == 1)
            bus(0, ICC_OFF_BUF, 0);
        end
        bus(1, ICC_OFF_IRQST, 7);
        // Wake mode with other control bits set
        bus(1, ICC_OFF_CTRL, 32'h2067);
        wakes = 0;
        cpu_sleep <= 1'b1;
        u_pin.pulses(1);
        cpu_sleep <= 1'b0;
        cpu_idle <= 1'b1;
        u_pin.pulses(1);
        cpu_idle <= 1'b0;
        u_pin.pulses(1);
        `CHK(wakes, 2)
        bus(0, ICC_OFF_CTRL, 0);
        `CHK(q[3], 1'b0)
        bus(0, ICC_OFF_IRQST, 0);
        `CHK(q, 32'h2)
        bus(1, ICC_OFF_IRQST, 7);
        cpu_idle <= 1'b1;
        bus(1, ICC_OFF_CTRL, 32'h2002);
        u_pin.pulses(1);
        bus(0, ICC_OFF_CTRL, 0);
        `CHK(q[3], 1'b0)
        bus(1, ICC_OFF_CTRL, 32'h0002);
        u_pin.pulses(1);
        cpu_idle <= 1'b0;
        bus(0, ICC_OFF_BUF, 0);
        `CHK(q, {16'h0, t3})
        test_done();
    end
endmodule
